// ---- logic/sfp_consts.svh ----
// constants for the switch forwarding policy block
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH
`define SFP_NPORTS 6
`define SFP_NPRIO 4
// global registers
`define SFP_OFF_MIRROR 12'h000
`define SFP_OFF_UNK_UC 12'h004
`define SFP_OFF_UNK_MC 12'h008
`define SFP_OFF_UNK_VID 12'h00c
`define SFP_OFF_EAPOL_RSV 12'h010
`define SFP_OFF_STATUS 12'h014
`define SFP_OFF_DROPS 12'h018
// per-port registers at 0xN000, N = port number 1..6
`define SFP_OFF_PORT_OPCTL 12'h020
`define SFP_OFF_PORT_SCHED 12'h024
`define SFP_OFF_PORT_ING_RATE 12'h028
`define SFP_OFF_PORT_EGR_RATE 12'h02c
`define SFP_OFF_PORT_RATE_OPT 12'h030
// port operation control fields
`define SFP_BIT_TAIL_TAG 2
`define SFP_BIT_RX_SNIFF 0
`define SFP_BIT_TX_SNIFF 1
`define SFP_BIT_AUTH 3
// mirror register fields
`define SFP_BIT_MIRROR_BAD 8
// frame classification
`define SFP_IP_VER_IGMP 4'h4
`define SFP_IGMP_PROTO_VER 4'h2
`define SFP_EAPOL_DA 48'h0180c2000003
`define SFP_EAPOL_LOW 8'h03
`define SFP_IFG_BYTES 16'h000c
`define SFP_PREAMBLE_BYTES 16'h0008
// rate units: one token per byte, bucket refilled every tick
`define SFP_RATE_TICK_NS 1000
`define SFP_CLK_NS 8
`define SFP_LINK_10_MBPS 8'h0a
`define SFP_LINK_100_MBPS 8'h64
`define SFP_BUCKET_DEPTH 24'h00ffff
`endif

// ---- logic/sfp_pkg.sv ----
// types for the switch forwarding policy block
`default_nettype none
package sfp_pkg;
  typedef logic [5:0] sfp_pmask_t;
  typedef enum logic [2:0] {
    SFP_CLS_ALL = 3'h0,
    SFP_CLS_MC = 3'h1,
    SFP_CLS_BC = 3'h2,
    SFP_CLS_FLOOD = 3'h3
  } sfp_cls_e;
  typedef enum logic [1:0] {
    SFP_LINK_10 = 2'h0,
    SFP_LINK_100 = 2'h1,
    SFP_LINK_1000 = 2'h2
  } sfp_speed_e;
  typedef enum logic [2:0] {
    SFP_EG_IDLE = 3'h1,
    SFP_EG_SEND = 3'h2,
    SFP_EG_GAP = 3'h4
  } sfp_eg_state_e;
endpackage
`default_nettype wire

// ---- logic/sfp_forwarding_policy.sv ----
// forwarding decision, mirroring, scheduling and rate limiting for a six-port switch
// How it works
// - tagging off at reset; tag bit in port opctl makes host port
// - igmp frames, ip version 4, protocol version 2, go only to host
// - known multicast goes only to its table port list
// - mld frames go only to the host port
// - rx sniff ports copy to mirror target; bad frames optional
// - tx sniff destinations also copy to mirror target
// - rx sniff source to tx sniff destination copies to target
// - many sniff sources allowed, any port may be target
// - each egress port selects strict priority or weighted round robin
// - strict priority: queue 3 highest, lower only when higher empty or short of egress tokens
// - weighted round robin favours higher queues without starving lower
// - ingress limiters per port per priority; egress limiters per queue, shared by all ports
// - rate above link speed means unlimited
// - ingress counts da to fcs, optionally plus ifg or preamble; egress counts eg_len
// - ingress limiter counts selected frame classes only
// - ingress drops frames once counted rate exceeds limit
// - egress leaky bucket per queue stretches inter-frame gap
// - exhausted buffer drops frames or asserts flow control
// - unknown destination floods all ports except source
// - unknown uc, mc, vid masks redirect; empty mask discards
// - eapol by fixed or reserved-domain address goes to host
// - host-bound frames carry tail byte, low bits receiving port
// - tag insert and removal only on the host port
//
// The register addresses and the APB slave port were decided locally.
`include "sfp_consts.svh"
`default_nettype none
module sfp_forwarding_policy #(
  parameter int NPORTS = `SFP_NPORTS,
  parameter int NPRIO = `SFP_NPRIO,
  parameter int RATE_TICK_CYC = (`SFP_RATE_TICK_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ingress frame descriptor, one-cycle strobe
  input wire logic fr_valid,
  input wire logic [2:0] fr_src,
  input wire logic [47:0] fr_da,
  input wire logic fr_is_ip4,
  input wire logic [3:0] fr_ip_ver,
  input wire logic [3:0] fr_igmp_ver,
  input wire logic fr_is_mld,
  input wire logic fr_bad,
  input wire logic [1:0] fr_prio,
  input wire logic [15:0] fr_len,
  input wire logic fr_hit,
  input wire logic [5:0] fr_hit_ports,
  input wire logic fr_vid_unknown,
  input wire logic fr_rsv_mc,
  input wire logic [3:0] fr_queue_full,
  // forwarding result
  output logic fwd_valid,
  output logic [5:0] fwd_ports,
  output logic fwd_drop,
  output logic fwd_tag_add,
  output logic [7:0] fwd_tag_byte,
  output logic fwd_strip_tag,
  output logic fwd_pause,
  // egress scheduler of one port, selected by eg_port
  input wire logic [2:0] eg_port,
  input wire logic [3:0] eg_pending,
  input wire logic [15:0] eg_len,
  input wire logic eg_done,
  output logic eg_grant_valid,
  output logic [1:0] eg_grant_q,
  // link speed per port
  input wire logic [11:0] link_speed
);
  import sfp_pkg::*;

  initial begin
    if (NPORTS != 6 || NPRIO != 4 || RATE_TICK_CYC < 1 || RATE_TICK_CYC > 256) begin
      $error("sfp_forwarding_policy: unsupported parameters");
    end
  end

  logic [7:0] opctl_reg [NPORTS];
  logic [1:0] sched_reg [NPORTS];
  logic [7:0] ing_rate_reg [NPORTS];
  logic [7:0] egr_rate_reg [NPORTS];
  logic [3:0] rate_opt_reg [NPORTS];
  logic [8:0] mirror_reg;
  sfp_pmask_t unk_uc_reg, unk_mc_reg, unk_vid_reg;
  logic [2:0] unk_en_reg;
  logic [7:0] eapol_rsv_reg;
  logic [15:0] drops_reg;
  logic [23:0] ing_bkt_reg [NPORTS*NPRIO];
  logic [23:0] egr_bkt_reg [NPRIO];
  logic [7:0] tick_cnt_reg;
  logic tick;

  wire [3:0] port_idx = paddr[15:12];
  wire [11:0] reg_off = paddr[11:0];
  wire port_hit = (port_idx >= 4'h1) && (port_idx <= 4'h6);
  wire [2:0] pi = 3'(port_idx - 4'h1);
  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && penable && !pwrite;

  // decode of the addressed register
  logic map_ok;
  logic [31:0] rd_val;
  always_comb begin
    map_ok = 1'b1;
    rd_val = 32'h0;
    if (port_idx == 4'h0) begin
      case (reg_off)
        `SFP_OFF_MIRROR: rd_val = {23'h0, mirror_reg};
        `SFP_OFF_UNK_UC: rd_val = {23'h0, unk_en_reg[0], 2'h0, unk_uc_reg};
        `SFP_OFF_UNK_MC: rd_val = {23'h0, unk_en_reg[1], 2'h0, unk_mc_reg};
        `SFP_OFF_UNK_VID: rd_val = {23'h0, unk_en_reg[2], 2'h0, unk_vid_reg};
        `SFP_OFF_EAPOL_RSV: rd_val = {24'h0, eapol_rsv_reg};
        `SFP_OFF_STATUS: rd_val = {28'h0, fr_queue_full};
        `SFP_OFF_DROPS: rd_val = {16'h0, drops_reg};
        default: map_ok = 1'b0;
      endcase
    end else if (port_hit) begin
      case (reg_off)
        `SFP_OFF_PORT_OPCTL: rd_val = {24'h0, opctl_reg[pi]};
        `SFP_OFF_PORT_SCHED: rd_val = {30'h0, sched_reg[pi]};
        `SFP_OFF_PORT_ING_RATE: rd_val = {24'h0, ing_rate_reg[pi]};
        `SFP_OFF_PORT_EGR_RATE: rd_val = {24'h0, egr_rate_reg[pi]};
        `SFP_OFF_PORT_RATE_OPT: rd_val = {28'h0, rate_opt_reg[pi]};
        default: map_ok = 1'b0;
      endcase
    end else begin
      map_ok = 1'b0;
    end
  end

  // apb answer registered in the access phase; pready one cycle per access
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !map_ok;
      prdata <= (apb_rd && !pready && map_ok) ? rd_val : 32'h0;
    end
  end

  wire wr_ok = apb_wr && pready && map_ok;

  // per-port registers
  genvar gp;
  generate
    for (gp = 0; gp < NPORTS; gp++) begin : g_port
      always_ff @(posedge clk) begin
        if (!nrst) begin
          opctl_reg[gp] <= 8'h0;
          sched_reg[gp] <= 2'h0;
          ing_rate_reg[gp] <= 8'hff;
          egr_rate_reg[gp] <= 8'hff;
          rate_opt_reg[gp] <= 4'h0;
        end else if (wr_ok && port_hit && pi == 3'(gp)) begin
          case (reg_off)
            `SFP_OFF_PORT_OPCTL: opctl_reg[gp] <= pwdata[7:0];
            `SFP_OFF_PORT_SCHED: sched_reg[gp] <= pwdata[1:0];
            `SFP_OFF_PORT_ING_RATE: ing_rate_reg[gp] <= pwdata[7:0];
            `SFP_OFF_PORT_EGR_RATE: egr_rate_reg[gp] <= pwdata[7:0];
            `SFP_OFF_PORT_RATE_OPT: rate_opt_reg[gp] <= pwdata[3:0];
            default: opctl_reg[gp] <= opctl_reg[gp];
          endcase
        end
      end
    end
  endgenerate

  // global registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mirror_reg <= 9'h0;
      unk_uc_reg <= 6'h0;
      unk_mc_reg <= 6'h0;
      unk_vid_reg <= 6'h0;
      unk_en_reg <= 3'h0;
      eapol_rsv_reg <= 8'h0;
    end else if (wr_ok && port_idx == 4'h0) begin
      case (reg_off)
        `SFP_OFF_MIRROR: mirror_reg <= pwdata[8:0];
        `SFP_OFF_UNK_UC: {unk_en_reg[0], unk_uc_reg} <= {pwdata[8], pwdata[5:0]};
        `SFP_OFF_UNK_MC: {unk_en_reg[1], unk_mc_reg} <= {pwdata[8], pwdata[5:0]};
        `SFP_OFF_UNK_VID: {unk_en_reg[2], unk_vid_reg} <= {pwdata[8], pwdata[5:0]};
        `SFP_OFF_EAPOL_RSV: eapol_rsv_reg <= pwdata[7:0];
        default: mirror_reg <= mirror_reg;
      endcase
    end
  end

  // host port, receive and transmit sniff and authorisation masks
  sfp_pmask_t host_m, rxs_m, txs_m, auth_m;
  generate
    for (gp = 0; gp < NPORTS; gp++) begin : g_mask
      assign host_m[gp] = opctl_reg[gp][`SFP_BIT_TAIL_TAG];
      assign rxs_m[gp] = opctl_reg[gp][`SFP_BIT_RX_SNIFF];
      assign txs_m[gp] = opctl_reg[gp][`SFP_BIT_TX_SNIFF];
      assign auth_m[gp] = opctl_reg[gp][`SFP_BIT_AUTH];
    end
  endgenerate
  wire tag_on = |host_m;
  wire [2:0] mir_tgt = mirror_reg[2:0];
  wire mir_en = mirror_reg[3];
  wire [5:0] src_m = 6'h1 << fr_src;

  // rate tick
  assign tick = (tick_cnt_reg == 8'(RATE_TICK_CYC - 1));
  always_ff @(posedge clk) begin
    if (!nrst || tick) begin
      tick_cnt_reg <= 8'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h1;
    end
  end

  // frame size for accounting
  function automatic logic [23:0] acct_len(input logic [15:0] len, input logic [3:0] opt);
    logic [15:0] s;
    s = len;
    if (opt[2]) s = s + `SFP_IFG_BYTES;
    if (opt[3]) s = s + `SFP_PREAMBLE_BYTES;
    return {8'h0, s};
  endfunction

  function automatic logic unlimited(input logic [7:0] rate, input logic [1:0] spd);
    return (spd == SFP_LINK_10 && rate > `SFP_LINK_10_MBPS) ||
           (spd == SFP_LINK_100 && rate > `SFP_LINK_100_MBPS) || rate == 8'hff;
  endfunction

  // forwarding decision
  logic [5:0] dest;
  logic drop_c, cls_hit, over_c;
  logic [4:0] bi;
  always_comb begin
    bi = 5'({fr_src, fr_prio});
    cls_hit = 1'b0;
    case (sfp_cls_e'({1'b0, rate_opt_reg[fr_src][1:0]}))
      SFP_CLS_ALL: cls_hit = 1'b1;
      SFP_CLS_MC: cls_hit = fr_da[40] && fr_da != 48'hffffffffffff;
      SFP_CLS_BC: cls_hit = fr_da == 48'hffffffffffff;
      SFP_CLS_FLOOD: cls_hit = !fr_hit && !fr_da[40];
      default: cls_hit = 1'b0;
    endcase
    over_c = cls_hit && !unlimited(ing_rate_reg[fr_src], link_speed[2*fr_src +: 2]) &&
             ing_bkt_reg[bi] < acct_len(fr_len, rate_opt_reg[fr_src]);
    drop_c = 1'b0;
    if (fr_hit) begin
      dest = fr_hit_ports;
    end else if (fr_vid_unknown && unk_en_reg[2]) begin
      dest = unk_vid_reg;
    end else if (fr_da[40] && unk_en_reg[1]) begin
      dest = unk_mc_reg;
    end else if (!fr_da[40] && unk_en_reg[0]) begin
      dest = unk_uc_reg;
    end else begin
      dest = ~src_m;
    end
    if (fr_is_ip4 && fr_ip_ver == `SFP_IP_VER_IGMP && fr_igmp_ver == `SFP_IGMP_PROTO_VER) begin
      dest = host_m;
    end
    if (fr_is_mld) dest = host_m;
    if (fr_da == `SFP_EAPOL_DA || (fr_rsv_mc && fr_da[7:0] == `SFP_EAPOL_LOW)) begin
      dest = host_m;
    end else if (!auth_m[fr_src]) begin
      dest = 6'h0;
    end
    if (fr_bad) dest = 6'h0;
    if (mir_en && (rxs_m[fr_src] || (|(dest & txs_m))) &&
        (!fr_bad || mirror_reg[`SFP_BIT_MIRROR_BAD])) begin
      dest = dest | (6'h1 << mir_tgt);
    end
    if (mir_en && mirror_reg[4] && |(dest & txs_m)) dest = dest | (6'h1 << mir_tgt);
    if (over_c) drop_c = 1'b1;
    // full queue drop unless flow control
    if (fr_queue_full[fr_prio] && !mirror_reg[5]) drop_c = 1'b1;
    if (dest == 6'h0) drop_c = 1'b1;
    if (drop_c) dest = 6'h0;
  end

  generate
    for (gp = 0; gp < NPORTS*NPRIO; gp++) begin : g_ibkt
      always_ff @(posedge clk) begin
        if (!nrst) begin
          ing_bkt_reg[gp] <= `SFP_BUCKET_DEPTH;
        end else if (fr_valid && bi == 5'(gp) && cls_hit && !over_c && !drop_c) begin
          ing_bkt_reg[gp] <= ing_bkt_reg[gp] - acct_len(fr_len, rate_opt_reg[gp/NPRIO]);
        end else if (tick && ing_bkt_reg[gp] < `SFP_BUCKET_DEPTH) begin
          ing_bkt_reg[gp] <= ing_bkt_reg[gp] + {16'h0, ing_rate_reg[gp/NPRIO]};
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      drops_reg <= 16'h0;
    end else if (fr_valid && drop_c && drops_reg != 16'hffff) begin
      drops_reg <= drops_reg + 16'h1;
    end
  end

  // result registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fwd_valid <= 1'b0;
      fwd_ports <= 6'h0;
      fwd_drop <= 1'b0;
      fwd_tag_add <= 1'b0;
      fwd_tag_byte <= 8'h0;
      fwd_strip_tag <= 1'b0;
      fwd_pause <= 1'b0;
    end else begin
      fwd_valid <= fr_valid;
      fwd_ports <= fr_valid ? dest : 6'h0;
      fwd_drop <= fr_valid && drop_c;
      fwd_tag_add <= fr_valid && tag_on && |(dest & host_m);
      fwd_tag_byte <= {5'h0, fr_src};
      fwd_strip_tag <= fr_valid && tag_on && host_m[fr_src];
      fwd_pause <= mirror_reg[5] && |fr_queue_full;
    end
  end

  // egress scheduler and shaper for the selected port
  sfp_eg_state_e eg_state_reg;
  logic [1:0] eg_q_reg;
  logic [3:0] wrr_cnt_reg [NPRIO];
  logic [3:0] elig;
  logic [1:0] pick;
  logic pick_ok, wrr_live;
  always_comb begin
    pick = 2'h0;
    pick_ok = 1'b0;
    wrr_live = 1'b0;
    for (int q = 0; q < NPRIO; q++) begin
      elig[q] = eg_pending[q] && (unlimited(egr_rate_reg[eg_port], link_speed[2*eg_port +: 2])
                || egr_bkt_reg[q] >= {8'h0, eg_len});
    end
    if (sched_reg[eg_port][0]) begin
      for (int q = 0; q < NPRIO; q++) begin
        if (elig[NPRIO-1-q] && wrr_cnt_reg[q] != 4'h0 && !pick_ok) begin
          pick = 2'(NPRIO - 1 - q);
          pick_ok = 1'b1;
          wrr_live = 1'b1;
        end
      end
      for (int q = 0; q < NPRIO; q++) begin
        if (elig[NPRIO-1-q] && !pick_ok) begin
          pick = 2'(NPRIO - 1 - q);
          pick_ok = 1'b1;
        end
      end
    end else begin
      for (int q = 0; q < NPRIO; q++) begin
        if (elig[q] && !pick_ok) begin
          pick = 2'(q);
          pick_ok = 1'b0 || (elig >> (q + 1)) == 4'h0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      eg_state_reg <= SFP_EG_IDLE;
      eg_q_reg <= 2'h0;
      eg_grant_valid <= 1'b0;
      eg_grant_q <= 2'h0;
    end else begin
      eg_grant_valid <= 1'b0;
      case (eg_state_reg)
        SFP_EG_IDLE: begin
          if (pick_ok) begin
            eg_q_reg <= pick;
            eg_grant_q <= pick;
            eg_grant_valid <= 1'b1;
            eg_state_reg <= SFP_EG_SEND;
          end
        end
        SFP_EG_SEND: if (eg_done) eg_state_reg <= SFP_EG_GAP;
        // gap held until the next rate tick
        SFP_EG_GAP: if (tick) eg_state_reg <= SFP_EG_IDLE;
        default: eg_state_reg <= SFP_EG_IDLE;
      endcase
    end
  end

  // weights 8/4/2/1 for queues 3..0, reloaded once no eligible queue has credit
  generate
    for (gp = 0; gp < NPRIO; gp++) begin : g_egq
      always_ff @(posedge clk) begin
        if (!nrst || !wrr_live) begin
          wrr_cnt_reg[gp] <= 4'(1 << (NPRIO - 1 - gp));
        end else if (eg_state_reg == SFP_EG_IDLE && pick_ok && pick == 2'(NPRIO - 1 - gp)
                     && wrr_cnt_reg[gp] != 4'h0) begin
          wrr_cnt_reg[gp] <= wrr_cnt_reg[gp] - 4'h1;
        end
      end
      always_ff @(posedge clk) begin
        if (!nrst) begin
          egr_bkt_reg[gp] <= `SFP_BUCKET_DEPTH;
        end else if (eg_state_reg == SFP_EG_IDLE && pick_ok && pick == 2'(gp)) begin
          egr_bkt_reg[gp] <= (egr_bkt_reg[gp] >= {8'h0, eg_len}) ?
                             egr_bkt_reg[gp] - {8'h0, eg_len} : 24'h0;
        end else if (tick && egr_bkt_reg[gp] < `SFP_BUCKET_DEPTH) begin
          egr_bkt_reg[gp] <= egr_bkt_reg[gp] + {16'h0, egr_rate_reg[eg_port]};
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- tb/sfp_forwarding_policy_props.sv ----
// concurrent checks on the forwarding policy ports
`include "sfp_consts.svh"
`default_nettype none
module sfp_forwarding_policy_props (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // frames
  input wire logic fr_valid,
  input wire logic [2:0] fr_src,
  input wire logic fr_is_ip4,
  input wire logic [3:0] fr_ip_ver,
  input wire logic [3:0] fr_igmp_ver,
  input wire logic fr_is_mld,
  input wire logic fr_bad,
  input wire logic fwd_valid,
  input wire logic [5:0] fwd_ports,
  input wire logic fwd_drop,
  input wire logic fwd_tag_add,
  input wire logic [7:0] fwd_tag_byte,
  // egress
  input wire logic [3:0] eg_pending,
  input wire logic eg_done,
  input wire logic eg_grant_valid,
  input wire logic [1:0] eg_grant_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // a grant is outstanding until the port reports done
  always_ff @(posedge clk) begin
    if (!nrst) busy_reg <= 1'b0;
    else if (eg_grant_valid) busy_reg <= 1'b1;
    else if (eg_done) busy_reg <= 1'b0;
  end
  sequence s_apb_wait; psel && penable && !pready; endsequence
  sequence s_igmp;
    fr_valid && fr_is_ip4 && fr_ip_ver == `SFP_IP_VER_IGMP &&
      fr_igmp_ver == `SFP_IGMP_PROTO_VER && !fr_bad;
  endsequence
  sequence s_mld; fr_valid && fr_is_mld && !fr_bad; endsequence
  property p_apb_answer; s_apb_wait |=> pready; endproperty
  property p_apb_pulse; pready |=> !pready; endproperty
  property p_apb_err; pslverr |-> pready; endproperty
  property p_fwd_lat; fr_valid |=> fwd_valid; endproperty
  property p_fwd_cause; fwd_valid |-> $past(fr_valid); endproperty
  property p_tag_byte;
    fwd_valid && fwd_tag_add |-> fwd_tag_byte == {5'h00, $past(fr_src)};
  endproperty
  property p_drop_empty; fwd_valid && fwd_drop |-> fwd_ports == 6'h00; endproperty
  property p_igmp_host; s_igmp ##1 fwd_tag_add |-> $onehot(fwd_ports); endproperty
  property p_mld_host; s_mld ##1 fwd_tag_add |-> $onehot(fwd_ports); endproperty
  property p_grant_pend;
    eg_grant_valid |-> (($past(eg_pending) >> eg_grant_q) & 4'h1) == 4'h1;
  endproperty
  property p_grant_gap; eg_grant_valid |-> !busy_reg; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready too long");
  a_apb_err: assert property (p_apb_err) else $error("pslverr without pready");
  a_fwd_lat: assert property (p_fwd_lat) else $error("no forwarding result");
  a_fwd_cause: assert property (p_fwd_cause) else $error("result without frame");
  a_tag_byte: assert property (p_tag_byte) else $error("tail byte port wrong");
  a_drop_empty: assert property (p_drop_empty) else $error("dropped frame has ports");
  a_igmp_host: assert property (p_igmp_host) else $error("igmp not host only");
  a_mld_host: assert property (p_mld_host) else $error("mld not host only");
  a_grant_pend: assert property (p_grant_pend) else $error("grant of empty queue");
  a_grant_gap: assert property (p_grant_gap) else $error("grant while busy");
endmodule
bind sfp_forwarding_policy sfp_forwarding_policy_props sfp_forwarding_policy_props_inst (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .fr_valid(fr_valid), .fr_src(fr_src), .fr_is_ip4(fr_is_ip4),
  .fr_ip_ver(fr_ip_ver), .fr_igmp_ver(fr_igmp_ver), .fr_is_mld(fr_is_mld), .fr_bad(fr_bad),
  .fwd_valid(fwd_valid), .fwd_ports(fwd_ports), .fwd_drop(fwd_drop),
  .fwd_tag_add(fwd_tag_add), .fwd_tag_byte(fwd_tag_byte), .eg_pending(eg_pending),
  .eg_done(eg_done), .eg_grant_valid(eg_grant_valid), .eg_grant_q(eg_grant_q));
`default_nettype wire

// ---- tb/sfp_egress_model.sv ----
// egress port model answering each grant with a done pulse
`default_nettype none
module sfp_egress_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // scheduler side
  input wire logic eg_grant_valid,
  input wire logic slow,
  output logic eg_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_reg <= 4'h0;
      eg_done <= 1'b0;
    end else begin
      eg_done <= cnt_reg == 4'h1;
      if (eg_grant_valid) cnt_reg <= slow ? 4'h9 : 4'h2;
      else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/sfp_forwarding_policy_tb.sv ----
// self-checking bench for the forwarding policy block
`include "sfp_consts.svh"
`default_nettype none
module sfp_forwarding_policy_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] UC = 48'h001122334455;
  localparam logic [47:0] MC = 48'h01005e000001;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, err, slow;
  logic [15:0] paddr, fr_len, eg_len;
  logic [31:0] pwdata, prdata, rd;
  logic fr_valid, fr_is_ip4, fr_is_mld, fr_bad, fr_hit, eg_done, eg_grant_valid;
  logic [2:0] fr_src, eg_port;
  logic [47:0] fr_da;
  logic [3:0] fr_ip_ver, fr_igmp_ver, eg_pending;
  logic [1:0] fr_prio, eg_grant_q, q;
  logic [5:0] fr_hit_ports, fwd_ports;
  logic fwd_valid, fwd_drop, fwd_tag_add, fwd_strip_tag, fwd_pause;
  logic [7:0] fwd_tag_byte;
  int errors, n_checks;
  sfp_forwarding_policy #(.RATE_TICK_CYC(20)) sfp_forwarding_policy_inst (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fr_valid(fr_valid), .fr_src(fr_src), .fr_da(fr_da), .fr_is_ip4(fr_is_ip4),
    .fr_ip_ver(fr_ip_ver), .fr_igmp_ver(fr_igmp_ver), .fr_is_mld(fr_is_mld),
    .fr_bad(fr_bad), .fr_prio(fr_prio), .fr_len(fr_len), .fr_hit(fr_hit),
    .fr_hit_ports(fr_hit_ports), .fr_vid_unknown(1'b0), .fr_rsv_mc(1'b0),
    .fr_queue_full(4'h0), .fwd_valid(fwd_valid), .fwd_ports(fwd_ports),
    .fwd_drop(fwd_drop), .fwd_tag_add(fwd_tag_add), .fwd_tag_byte(fwd_tag_byte),
    .fwd_strip_tag(fwd_strip_tag), .fwd_pause(fwd_pause), .eg_port(eg_port),
    .eg_pending(eg_pending), .eg_len(eg_len), .eg_done(eg_done),
    .eg_grant_valid(eg_grant_valid), .eg_grant_q(eg_grant_q), .link_speed(12'haaa));
  sfp_egress_model sfp_egress_model_inst (
    .clk(clk), .nrst(nrst), .eg_grant_valid(eg_grant_valid), .slow(slow), .eg_done(eg_done));
  task automatic final_report();
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] pa(input logic [2:0] p, input logic [11:0] off);
    return {1'b0, p + 3'd1, off};
  endfunction
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // kind: 0 plain, 1 igmp, 2 mld, 3 igmp header of another version; host is port index 2
  task automatic frm(input logic [2:0] src, input logic [47:0] da, input logic [2:0] kind,
                     input logic [5:0] hp, input logic [5:0] ep, input logic ed);
    @(posedge clk);
    fr_valid <= 1'b1;
    fr_src <= src;
    fr_da <= da;
    fr_hit <= hp != 6'h00;
    fr_hit_ports <= hp;
    fr_is_ip4 <= kind == 3'h1 || kind == 3'h3;
    fr_igmp_ver <= kind == 3'h3 ? 4'h3 : 4'h2;
    fr_is_mld <= kind == 3'h2;
    fr_prio <= src[1:0];
    fr_len <= 16'h0040 + 16'(src);
    @(posedge clk);
    fr_valid <= 1'b0;
    @(posedge clk);
    chk("fwd_valid", 48'(fwd_valid), 48'h1);
    chk("fwd_ports", 48'(fwd_ports), 48'(ep));
    chk("fwd_drop", 48'(fwd_drop), 48'(ed));
    chk("fwd_tag_add", 48'(fwd_tag_add), 48'(ep[2]));
    chk("fwd_strip_tag", 48'(fwd_strip_tag), 48'(src == 3'h2));
    if (ep[2]) chk("fwd_tag_byte", 48'(fwd_tag_byte), 48'(src));
  endtask
  task automatic grant();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (eg_grant_valid !== 1'b1 && n < 400);
    if (n >= 400) errors++;
    q = eg_grant_q;
  endtask
  task automatic t_reset();
    apb(1'b0, pa(3'h0, `SFP_OFF_PORT_OPCTL), 32'h0);
    chk("opctl_reset", 48'(rd), 48'h0);
    apb(1'b0, pa(3'h0, `SFP_OFF_PORT_ING_RATE), 32'h0);
    chk("ing_rate_reset", 48'(rd), 48'hff);
    apb(1'b0, 16'h0100, 32'h0);
    chk("unmapped_err", 48'(err), 48'h1);
    chk("unmapped_data", 48'(rd), 48'h0);
  endtask
  task automatic t_setup();
    // authorise all, tail tag only on port index 2
    for (int p = 0; p < 6; p++) begin
      apb(1'b1, pa(3'(p), `SFP_OFF_PORT_OPCTL), p == 2 ? 32'hc : 32'h8);
    end
  endtask
  task automatic t_trap();
    frm(3'h0, UC, 3'h1, 6'h00, 6'h04, 1'b0);
    frm(3'h4, UC, 3'h3, 6'h00, 6'h2f, 1'b0);
    frm(3'h5, UC, 3'h2, 6'h00, 6'h04, 1'b0);
    frm(3'h1, `SFP_EAPOL_DA, 3'h0, 6'h00, 6'h04, 1'b0);
    frm(3'h0, MC, 3'h0, 6'h30, 6'h30, 1'b0);
    frm(3'h3, MC, 3'h0, 6'h00, 6'h37, 1'b0);
    frm(3'h2, UC, 3'h0, 6'h01, 6'h01, 1'b0);
  endtask
  task automatic t_unknown();
    apb(1'b1, `SFP_OFF_UNK_UC, 32'h108);
    frm(3'h0, UC, 3'h0, 6'h00, 6'h08, 1'b0);
    apb(1'b1, `SFP_OFF_UNK_UC, 32'h100);
    frm(3'h0, UC, 3'h0, 6'h00, 6'h00, 1'b1);
    apb(1'b1, `SFP_OFF_UNK_UC, 32'h0);
  endtask
  task automatic t_auth();
    apb(1'b1, pa(3'h1, `SFP_OFF_PORT_OPCTL), 32'h0);
    frm(3'h1, UC, 3'h0, 6'h01, 6'h00, 1'b1);
    frm(3'h1, `SFP_EAPOL_DA, 3'h0, 6'h00, 6'h04, 1'b0);
    apb(1'b1, pa(3'h1, `SFP_OFF_PORT_OPCTL), 32'h8);
  endtask
  task automatic t_mirror();
    apb(1'b1, `SFP_OFF_MIRROR, 32'h1d);
    apb(1'b1, pa(3'h0, `SFP_OFF_PORT_OPCTL), 32'h9);
    apb(1'b1, pa(3'h3, `SFP_OFF_PORT_OPCTL), 32'ha);
    frm(3'h0, UC, 3'h0, 6'h02, 6'h22, 1'b0);
    frm(3'h1, UC, 3'h0, 6'h08, 6'h28, 1'b0);
    frm(3'h0, UC, 3'h0, 6'h08, 6'h28, 1'b0);
    frm(3'h0, UC, 3'h0, 6'h20, 6'h20, 1'b0);
    frm(3'h4, UC, 3'h0, 6'h02, 6'h02, 1'b0);
    apb(1'b1, `SFP_OFF_MIRROR, 32'h0a);
    frm(3'h0, UC, 3'h0, 6'h02, 6'h06, 1'b0);
    apb(1'b1, `SFP_OFF_MIRROR, 32'h0);
    apb(1'b1, pa(3'h0, `SFP_OFF_PORT_OPCTL), 32'h8);
    apb(1'b1, pa(3'h3, `SFP_OFF_PORT_OPCTL), 32'h8);
  endtask
  task automatic t_sched();
    int c3, c0;
    c3 = 0;
    c0 = 0;
    eg_pending <= 4'h6;
    grant();
    chk("sp_grant_q2", 48'(q), 48'h2);
    eg_pending <= 4'hb;
    grant();
    chk("sp_grant_q3", 48'(q), 48'h3);
    eg_pending <= 4'h0;
    apb(1'b1, pa(3'h0, `SFP_OFF_PORT_SCHED), 32'h1);
    slow <= 1'b1;
    eg_pending <= 4'h9;
    for (int i = 0; i < 9; i++) begin
      eg_len <= 16'h0040 + 16'(i);
      grant();
      if (q === 2'h3) c3++;
      if (q === 2'h0) c0++;
    end
    chk("wrr_low_served", 48'(c0 > 0), 48'h1);
    chk("wrr_high_favoured", 48'(c3 > c0), 48'h1);
    eg_pending <= 4'h1;
    grant();
    chk("wrr_q0_alone", 48'(q), 48'h0);
    eg_pending <= 4'h0;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    errors = 0;
    n_checks = 0;
    {nrst, psel, penable, pwrite, fr_valid, fr_is_ip4, fr_is_mld, fr_bad, fr_hit} = '0;
    {paddr, pwdata, fr_src, fr_da, fr_igmp_ver, fr_prio, fr_len, fr_hit_ports} = '0;
    fr_ip_ver = `SFP_IP_VER_IGMP;
    {eg_port, eg_pending, slow} = '0;
    eg_len = 16'h0040;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_setup();
    t_trap();
    t_unknown();
    t_auth();
    t_mirror();
    t_sched();
    final_report();
  end
  initial begin
    #160000;
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
